// [enc_index_consts.svh]
/*
 encoder index latch constants: register offsets, field positions, reset values.
 included by the package and by the design files; definitions only.
*/
// Summary of operation
// - decimal bit zero: fraction in 1/65536
// - decimal bit one: fraction in 1/10000
// - position-latch option also captures ramp position
// - clear off: event only latches count
// - clear on: latch then zero counter
// - edge bits select level, rise, fall, both
// - one-shot latches only first event after write
// - continuous latches every event; prefer edges
// - AB checked: index, A, B must match
// - ignore-quadrature disregards A and B
// - index polarity bit sets active level
// - bits 1,0 give required B, A levels
// - counter adds signed 16.16 constant per step
// - read-only 32-bit latch holds captured count
// - index event sets W1C flag, drives interrupt
`ifndef ENC_INDEX_CONSTS_SVH
`define ENC_INDEX_CONSTS_SVH

// register indices; 0x3D is left free for a deviation register
`define IDX_CONFIG 6'h38
`define IDX_COUNT 6'h39
`define IDX_CONST 6'h3A
`define IDX_STATUS 6'h3B
`define IDX_LATCH 6'h3C
`define IDX_POS_LATCH 6'h3E
`define IDX_IRQ_MASK 6'h3F
// byte address is four times the index: one aligned word per register
`define ADDR_CONFIG {`IDX_CONFIG, 2'h0}
`define ADDR_COUNT {`IDX_COUNT, 2'h0}
`define ADDR_CONST {`IDX_CONST, 2'h0}
`define ADDR_STATUS {`IDX_STATUS, 2'h0}
`define ADDR_LATCH {`IDX_LATCH, 2'h0}
`define ADDR_POS_LATCH {`IDX_POS_LATCH, 2'h0}
`define ADDR_IRQ_MASK {`IDX_IRQ_MASK, 2'h0}

`define CFG_WIDTH 11
`define CFG_RESET 11'h000
`define CONST_RESET 32'h00010000
`define MASK_RESET 1'h0
`define DEC_STEP 17'h02710

`define BIT_DECIMAL 10
`define BIT_LATCH_POS 9
`define BIT_CLR_COUNT 8
`define BIT_FALL 7
`define BIT_RISE 6
`define BIT_ONCE 5
`define BIT_CONT 4
`define BIT_IGNORE_QUADRATURE 3
`define BIT_POL_N 2
`define BIT_POL_B 1
`define BIT_POL_A 0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [enc_index_pkg.sv]
/*
 types for the encoder index latch.
 assumes enc_index_consts.svh is on the include path.
*/
`include "enc_index_consts.svh"
package enc_index_pkg;
   typedef struct packed {
      logic a;
      logic b;
      logic n;
   } quad_pins_type;

   typedef struct packed {
      logic decimal;
      logic latch_pos;
      logic clr_count;
      logic fall;
      logic rise;
      logic once;
      logic cont;
      logic ignore_quadrature;
      logic pol_n;
      logic pol_b;
      logic pol_a;
   } index_cfg_type;

   typedef enum logic [1:0] {
      wr_idle,
      wr_resp
   } wr_state_type;
endpackage

// [encoder_index_latch.sv]
/*
 quadrature encoder counter with index (N) event qualification and latching,
 AXI4-Lite register slave, one level interrupt.
 assumes a ramp generator supplies its actual position on the same clock,
 and encoder pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "enc_index_consts.svh"
module encoder_index_latch (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // encoder pins
   input wire enc_index_pkg::quad_pins_type enc_pins,
   // ramp generator
   input wire logic [31:0] ramp_actual_position,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   output logic irq
);
   import enc_index_pkg::*;

   logic pin_a;
   logic pin_b;
   logic pin_n;

   pin_sync sync_a (.clk(clk), .rst_n(rst_n), .pin(enc_pins.a), .level(pin_a));
   pin_sync sync_b (.clk(clk), .rst_n(rst_n), .pin(enc_pins.b), .level(pin_b));
   pin_sync sync_n (.clk(clk), .rst_n(rst_n), .pin(enc_pins.n), .level(pin_n));

   // register state
   index_cfg_type cfg_q, cfg_d;
   logic [31:0] const_q, const_d;
   logic [31:0] count_q, count_d;
   logic [16:0] dec_frac_q, dec_frac_d;
   logic [31:0] latch_q, latch_d;
   logic [31:0] pos_latch_q, pos_latch_d;
   logic event_flag_q, event_flag_d;
   logic irq_mask_q, irq_mask_d;
   logic armed_once_q, armed_once_d;
   logic prev_a_q, prev_b_q, prev_match_q;
   logic irq_q, irq_d;

   // bus state
   wr_state_type wr_state_q, wr_state_d;
   logic aw_held_q, aw_held_d;
   logic w_held_q, w_held_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic arready_q, arready_d, bvalid_q, bvalid_d;

   // quadrature decode and index qualification
   logic step_up, step_dn, step;
   logic n_active, ab_match, index_match, index_event, do_latch;
   logic [31:0] add_val;
   logic [31:0] count_next;
   logic wr_fire;
   logic [31:0] wr_mask;

   always_comb begin
      step_up = 1'b0;
      step_dn = 1'b0;
      // gray sequence 00,01,11,10 counts up
      if ((pin_a ^ prev_a_q) && !(pin_b ^ prev_b_q)) begin
         step_up = (pin_a != pin_b);
         step_dn = (pin_a == pin_b);
      end else if ((pin_b ^ prev_b_q) && !(pin_a ^ prev_a_q)) begin
         step_up = (pin_a == pin_b);
         step_dn = (pin_a != pin_b);
      end
      step = step_up | step_dn;

      n_active = (pin_n == cfg_q.pol_n);
      ab_match = (pin_a == cfg_q.pol_a) && (pin_b == cfg_q.pol_b);
      index_match = n_active && (cfg_q.ignore_quadrature || ab_match);
      case ({cfg_q.fall, cfg_q.rise})
         2'b00: index_event = index_match;
         2'b01: index_event = index_match && !prev_match_q;
         2'b10: index_event = !index_match && prev_match_q;
         default: index_event = index_match ^ prev_match_q;
      endcase
      do_latch = index_event && (cfg_q.cont || armed_once_q);
   end

   // counter accumulation
   always_comb begin
      add_val = const_q;
      dec_frac_d = dec_frac_q;
      if (cfg_q.decimal) begin
         // fraction steps in 1/10000, carry into integer part
         add_val = {const_q[31:16], 16'h0000};
         if (step) begin
            if (step_up)
               dec_frac_d = dec_frac_q + {1'b0, const_q[15:0]};
            else
               dec_frac_d = dec_frac_q - {1'b0, const_q[15:0]};
            if (!dec_frac_d[16] && dec_frac_d >= `DEC_STEP) begin
               dec_frac_d = dec_frac_d - `DEC_STEP;
               add_val = add_val + (step_up ? `CONST_RESET : -`CONST_RESET);
            end else if (dec_frac_d[16]) begin
               dec_frac_d = dec_frac_d + `DEC_STEP;
               add_val = add_val + (step_up ? -`CONST_RESET : `CONST_RESET);
            end
         end
      end
      // binary mode adds the full 16.16 constant
      // signed constant sets direction
      if (step_up)
         count_next = count_q + add_val;
      else if (step_dn)
         count_next = count_q - add_val;
      else
         count_next = count_q;
   end

   // write channel acceptance; address and data in either order
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      wr_state_d = wr_state_q;
      bresp_d = bresp_q;
      wr_fire = 1'b0;
      if (s_axi_awvalid && !aw_held_q && wr_state_q == wr_idle) begin
         aw_held_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && wr_state_q == wr_idle) begin
         w_held_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      case (wr_state_q)
         wr_idle: begin
            if (aw_held_q && w_held_q) begin
               wr_fire = 1'b1;
               aw_held_d = 1'b0;
               w_held_d = 1'b0;
               wr_state_d = wr_resp;
               case (aw_addr_q)
                  `ADDR_CONFIG, `ADDR_COUNT, `ADDR_CONST, `ADDR_STATUS,
                  `ADDR_IRQ_MASK: bresp_d = `RESP_OKAY;
                  default: bresp_d = `RESP_SLVERR;
               endcase
            end
         end
         wr_resp: begin
            if (s_axi_bready)
               wr_state_d = wr_idle;
         end
         default: wr_state_d = wr_idle;
      endcase
      wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   end

   // register updates
   always_comb begin
      cfg_d = cfg_q;
      const_d = const_q;
      irq_mask_d = irq_mask_q;
      armed_once_d = armed_once_q;
      count_d = count_next;
      latch_d = latch_q;
      pos_latch_d = pos_latch_q;
      event_flag_d = event_flag_q;
      if (wr_fire) begin
         case (aw_addr_q)
            `ADDR_CONFIG: begin
               cfg_d = index_cfg_type'((cfg_q & ~wr_mask[`CFG_WIDTH-1:0])
                  | (w_data_q[`CFG_WIDTH-1:0] & wr_mask[`CFG_WIDTH-1:0]));
               armed_once_d = cfg_d.once;
            end
            `ADDR_COUNT: count_d = (count_q & ~wr_mask) | (w_data_q & wr_mask);
            `ADDR_CONST: const_d = (const_q & ~wr_mask) | (w_data_q & wr_mask);
            `ADDR_STATUS: begin
               if (w_strb_q[0] && w_data_q[0])
                  event_flag_d = 1'b0;
            end
            `ADDR_IRQ_MASK: begin
               if (w_strb_q[0])
                  irq_mask_d = w_data_q[0];
            end
            default: ;
         endcase
      end
      if (index_event)
         event_flag_d = 1'b1; // set wins over clear
      if (do_latch) begin
         latch_d = count_q;
         if (cfg_q.latch_pos)
            pos_latch_d = ramp_actual_position;
         if (cfg_q.clr_count)
            count_d = 32'h00000000;
         if (!cfg_q.cont)
            armed_once_d = 1'b0;
      end
      irq_d = event_flag_d & irq_mask_d;
   end

   // read channel
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = `RESP_OKAY;
         case (s_axi_araddr)
            `ADDR_CONFIG: rdata_d = {21'h0, cfg_q};
            `ADDR_COUNT: rdata_d = count_q;
            `ADDR_CONST: rdata_d = const_q;
            `ADDR_STATUS: rdata_d = {31'h0, event_flag_q};
            `ADDR_LATCH: rdata_d = latch_q;
            `ADDR_POS_LATCH: rdata_d = pos_latch_q;
            `ADDR_IRQ_MASK: rdata_d = {31'h0, irq_mask_q};
            default: begin
               rdata_d = 32'h00000000;
               rresp_d = `RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= index_cfg_type'(`CFG_RESET);
         const_q <= `CONST_RESET;
         count_q <= 32'h00000000;
         dec_frac_q <= 17'h00000;
         latch_q <= 32'h00000000;
         pos_latch_q <= 32'h00000000;
         event_flag_q <= 1'b0;
         irq_mask_q <= `MASK_RESET;
         armed_once_q <= 1'b0;
         prev_a_q <= 1'b0;
         prev_b_q <= 1'b0;
         prev_match_q <= 1'b0;
         irq_q <= 1'b0;
         wr_state_q <= wr_idle;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
         bvalid_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         const_q <= const_d;
         count_q <= count_d;
         dec_frac_q <= dec_frac_d;
         latch_q <= latch_d;
         pos_latch_q <= pos_latch_d;
         event_flag_q <= event_flag_d;
         irq_mask_q <= irq_mask_d;
         armed_once_q <= armed_once_d;
         prev_a_q <= pin_a;
         prev_b_q <= pin_b;
         prev_match_q <= index_match;
         irq_q <= irq_d;
         wr_state_q <= wr_state_d;
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
         bvalid_q <= bvalid_d;
      end
   end

   // ready only while the holding slot is free: one write in flight
   // taken from next state so the pins are flops yet track the state
   always_comb begin
      awready_d = !aw_held_d && wr_state_d == wr_idle;
      wready_d = !w_held_d && wr_state_d == wr_idle;
      arready_d = !rvalid_d;
      bvalid_d = (wr_state_d == wr_resp);
   end
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_arready = arready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// [encoder_index_latch_checker.sv]
/*
 bus handshake and interrupt checks for encoder_index_latch.
 assumes only the top-level ports; bound at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module encoder_index_latch_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0
      || s_axi_bresp == 2'h2) else $error("bad write response code");
   irq_clear_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("interrupt fell without a write");
endmodule
bind encoder_index_latch encoder_index_latch_checker u_chk (.clk, .rst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

// [encoder_index_latch_test.sv]
/*
 self-checking bench for encoder_index_latch.
 assumes the encoder model and the bound checker; registers reached over axi4-lite.
*/
`timescale 1ns/1ps
`default_nettype none
`include "enc_index_consts.svh"
module encoder_index_latch_test;
   import enc_index_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, irq;
   quad_pins_type enc_pins;
   logic [31:0] ramp_actual_position, s_axi_wdata, s_axi_rdata;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int fail_count = 0, check_count = 0, cycles = 0;
   always #10 clk = ~clk;
   quad_encoder_model u_quad_encoder_model (.clk, .pins(enc_pins));
   encoder_index_latch u_encoder_index_latch (.clk, .rst_n, .enc_pins, .ramp_actual_position,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      // generous: all scenarios need well under 5000 cycles
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bready <= 1'b0;
            check(32'(s_axi_bresp), 32'(er));
         end
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rready <= 1'b0;
            check(s_axi_rdata, ed);
            check(32'(s_axi_rresp), 32'(er));
         end
      end while (s_axi_arvalid || s_axi_rready);
   endtask
   task automatic pulse_n;
      u_quad_encoder_model.set_n(1'b1);
      u_quad_encoder_model.set_n(1'b0);
   endtask
   task automatic reset_and_map;
      rd(`ADDR_CONST, `CONST_RESET, `RESP_OKAY);
      s_axi_wstrb <= 4'hC;
      wr(`ADDR_CONST, 32'h0003FFFF, `RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(`ADDR_CONST, 32'h00030000, `RESP_OKAY);
      wr(`ADDR_CONST, `CONST_RESET, `RESP_OKAY);
      rd(`ADDR_LATCH, 32'h0, `RESP_OKAY);
      wr(`ADDR_LATCH, 32'h5, `RESP_SLVERR);
      rd(8'h80, 32'h0, `RESP_SLVERR);
      wr(8'h80, 32'h1, `RESP_SLVERR);
   endtask
   task automatic scaling;
      wr(`ADDR_CONST, 32'h00011388, `RESP_OKAY);
      wr(`ADDR_COUNT, 32'h0, `RESP_OKAY);
      u_quad_encoder_model.step(2);
      rd(`ADDR_COUNT, 32'h00022710, `RESP_OKAY);
      wr(`ADDR_CONFIG, 32'h400, `RESP_OKAY);
      wr(`ADDR_COUNT, 32'h0, `RESP_OKAY);
      u_quad_encoder_model.step(2);
      rd(`ADDR_COUNT, 32'h00030000, `RESP_OKAY);
      wr(`ADDR_CONST, `CONST_RESET, `RESP_OKAY);
   endtask
   task automatic clear_continuous;
      wr(`ADDR_IRQ_MASK, 32'h1, `RESP_OKAY);
      wr(`ADDR_CONFIG, 32'h15C, `RESP_OKAY);
      wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      check(32'(irq), 32'h0);
      wr(`ADDR_COUNT, 32'h0, `RESP_OKAY);
      u_quad_encoder_model.step(5);
      pulse_n();
      rd(`ADDR_LATCH, 32'h00050000, `RESP_OKAY);
      rd(`ADDR_COUNT, 32'h0, `RESP_OKAY);
      check(32'(irq), 32'h1);
      wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0);
      u_quad_encoder_model.step(2);
      pulse_n();
      rd(`ADDR_LATCH, 32'h00020000, `RESP_OKAY);
   endtask
   task automatic once_with_position;
      wr(`ADDR_CONFIG, 32'h26C, `RESP_OKAY);
      wr(`ADDR_COUNT, 32'h0, `RESP_OKAY);
      u_quad_encoder_model.step(3);
      pulse_n();
      rd(`ADDR_LATCH, 32'h00030000, `RESP_OKAY);
      rd(`ADDR_POS_LATCH, 32'h0000ABCD, `RESP_OKAY);
      rd(`ADDR_COUNT, 32'h00030000, `RESP_OKAY);
      ramp_actual_position <= 32'h00001234;
      u_quad_encoder_model.step(1);
      pulse_n();
      rd(`ADDR_LATCH, 32'h00030000, `RESP_OKAY);
      rd(`ADDR_POS_LATCH, 32'h0000ABCD, `RESP_OKAY);
   endtask
   task automatic qualify;
      logic [31:0] cfg [3] = '{32'h57, 32'h9C, 32'h58};
      for (int i = 0; i < 3; i++) begin
         wr(`ADDR_CONFIG, cfg[i], `RESP_OKAY);
         wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
         if (i == 0) begin
            u_quad_encoder_model.set_ab(1'b0, 1'b0);
            pulse_n();
            rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
            u_quad_encoder_model.set_ab(1'b1, 1'b1);
            pulse_n();
         end else begin
            u_quad_encoder_model.set_n(1'b1);
            rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
            u_quad_encoder_model.set_n(1'b0);
         end
         rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      end
      wr(`ADDR_CONFIG, 32'hDC, `RESP_OKAY);
      wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      u_quad_encoder_model.set_n(1'b1);
      rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      u_quad_encoder_model.set_n(1'b0);
      rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      wr(`ADDR_CONFIG, 32'h0C, `RESP_OKAY);
      u_quad_encoder_model.set_n(1'b1);
      wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      u_quad_encoder_model.set_n(1'b0);
      wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
   endtask
   initial begin
      ramp_actual_position <= 32'h0000ABCD;
      s_axi_wdata <= 32'h00000000;
      s_axi_awaddr <= 8'h00;
      s_axi_araddr <= 8'h00;
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
      {s_axi_arvalid, s_axi_rready} <= 2'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      reset_and_map();
      scaling();
      clear_continuous();
      once_with_position();
      qualify();
      complete_run();
   end
endmodule
`default_nettype wire

// [pin_sync.sv]
/*
 three-stage synchroniser with agreement filter for one pin.
 assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin in, filtered level out
   input wire logic pin,
   output logic level
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic level_q;
   logic level_d;

   always_comb begin
      sync_d = {sync_q[1:0], pin};
      // first stage feeds only the second
      level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= 3'h0;
         level_q <= 1'h0;
      end else begin
         sync_q <= sync_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule
`default_nettype wire

// [quad_encoder_model.sv]
/*
 incremental encoder with index channel, driven by tasks.
 assumes the caller runs on clk; each change is held 8 cycles for the synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
   // clock
   input wire logic clk,
   // encoder pins
   output var enc_index_pkg::quad_pins_type pins
);
   import enc_index_pkg::*;
   logic [1:0] ph = 2'h0;
   initial pins = '0;
   // gray order {b,a} 00,01,11,10 (a leads) is one count up per change
   task automatic step(input int k);
      repeat (k) begin
         @(posedge clk);
         ph = ph + 2'h1;
         pins.a <= ph[1] ^ ph[0];
         pins.b <= ph[1];
         repeat (8) @(posedge clk);
      end
   endtask
   task automatic set_ab(input logic a, input logic b);
      @(posedge clk);
      ph = {b, a ^ b};
      pins.a <= a;
      pins.b <= b;
      repeat (8) @(posedge clk);
   endtask
   task automatic set_n(input logic v);
      @(posedge clk);
      pins.n <= v;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire
